/* rtl/usb_iface_mgr_regs.svh */
`ifndef USB_IFACE_MGR_REGS_SVH
`define USB_IFACE_MGR_REGS_SVH

// ****************************************
// register offsets
// ****************************************
`define OFS_LAST_PACKET_ID 8'h2C
`define OFS_LAST_ENDPOINT 8'h30
`define OFS_ENDPOINT_TAG_MASK 8'h34
`define OFS_OTG_FLAG_MASK 8'h38
`define OFS_POWER_SIGNALLING 8'h3C
`define OFS_TRANSCEIVER_CONTROL 8'h40
`define OFS_IRQ_STATUS 8'h44
`define OFS_IRQ_MASK 8'h48

// ****************************************
// field positions
// ****************************************
`define EP_VALID_BIT 4
`define PULLDOWN_OFF_BIT 18
`define CAUSE_RESET_BIT 13
`define CAUSE_RESUME_BIT 12
`define FILTER_LSB 8
`define FILTER_MSB 11
`define SUSPEND_EN_BIT 7
`define CONF_LSB 4
`define CONF_MSB 6
`define POWER_VALID_BIT 8
`define EP_TAG_OR 5'h10

// irq status bit positions
`define IRQ_PACKET 0
`define IRQ_RESET 1
`define IRQ_RESUME 2
`define IRQ_SUSPEND 3

// ****************************************
// reset values and timing
// ****************************************
`define RESET_WORD 32'h0000_0000
`define CTRL_WRITE_MASK 32'h0004_3FF0
`define SUSPEND_TIME_US 3000
`define CLK_MHZ 20
`define SUSPEND_CYCLES (`SUSPEND_TIME_US * `CLK_MHZ)

`endif

/* rtl/usb_iface_mgr_pkg.sv */
package usb_iface_mgr_pkg;

  typedef enum logic [1:0] {
    LINE_SE0 = 2'b00,
    LINE_J = 2'b01,
    LINE_K = 2'b10,
    LINE_SE1 = 2'b11
  } line_state_t;

  typedef struct packed {
    logic valid;
    logic isToken;
    logic [3:0] pid;
    logic [3:0] endpoint;
  } rx_packet_t;

  typedef struct packed {
    logic valid;
    logic [4:0] endpoint;
  } rx_tag_t;

  typedef enum logic [1:0] {
    PWR_ACTIVE = 2'b00,
    PWR_SUSPENDED = 2'b01,
    PWR_RESUMING = 2'b10
  } power_state_t;

endpackage : usb_iface_mgr_pkg

/* rtl/line_state_filter.sv */
module line_state_filter #(
  parameter int MAX_LOG2 = 15
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [1:0] lineRaw,
  input wire logic [3:0] log2Clocks,
  output logic [1:0] lineFilt
);
  // ****************************************
  // change propagates after 2**log2Clocks stable clocks
  // ****************************************
  logic [1:0] candReg;
  logic [MAX_LOG2:0] cntReg;
  logic [MAX_LOG2:0] target;
  wire changed = (lineRaw != candReg);

  assign target = (MAX_LOG2 + 1)'(1) << log2Clocks;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      candReg <= 2'h1;
      cntReg <= '0;
      lineFilt <= 2'h1;
    end else if (changed) begin
      candReg <= lineRaw;
      cntReg <= (MAX_LOG2 + 1)'(1);
    end else if (lineFilt != candReg) begin
      if (cntReg >= target) begin
        lineFilt <= candReg;
      end else begin
        cntReg <= cntReg + (MAX_LOG2 + 1)'(1);
      end
    end
  end
endmodule : line_state_filter

/* rtl/usb_phy_info_ctrl.sv */
`include "usb_iface_mgr_regs.svh"
module usb_phy_info_ctrl #(
  parameter int SUSPEND_CYCLES = `SUSPEND_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire usb_iface_mgr_pkg::rx_packet_t rxPacket,
  input wire logic [1:0] lineStatePin,
  output usb_iface_mgr_pkg::rx_tag_t rxTag,
  output logic [1:0] lineStateFilt,
  output logic [2:0] transceiver_config_pins,
  output logic pulldownOff,
  output logic suspendMode,
  output logic irq
);
  // ****************************************
  // pin synchroniser
  // ****************************************
  logic [1:0] lineMetaReg;
  logic [1:0] lineSyncReg;
  logic [1:0] lineFilt;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      lineMetaReg <= 2'h1;
      lineSyncReg <= 2'h1;
    end else begin
      lineMetaReg <= lineStatePin;
      lineSyncReg <= lineMetaReg;
    end
  end

  // ****************************************
  // register state
  // ****************************************
  logic [3:0] pidReg;
  logic [3:0] epReg;
  logic epValidReg;
  logic [15:0] tagMaskReg;
  logic [31:0] otgMaskReg;
  logic [8:0] powerReg;
  logic [31:0] ctrlReg;
  logic [3:0] irqStatReg;
  logic [3:0] irqMaskReg;

  line_state_filter u_filter (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .lineRaw(lineSyncReg),
    .log2Clocks(ctrlReg[`FILTER_MSB:`FILTER_LSB]),
    .lineFilt(lineFilt)
  );

  // ****************************************
  // apb decode
  // ****************************************
  wire access = psel && penable;
  wire wrEn = access && pwrite;
  wire [7:0] ofs = paddr[7:0];
  wire inRange = (paddr[31:8] == 24'h000000) && (paddr[1:0] == 2'h0);
  wire hitPid = inRange && ofs == `OFS_LAST_PACKET_ID;
  wire hitEp = inRange && ofs == `OFS_LAST_ENDPOINT;
  wire hitTag = inRange && ofs == `OFS_ENDPOINT_TAG_MASK;
  wire hitOtg = inRange && ofs == `OFS_OTG_FLAG_MASK;
  wire hitPwr = inRange && ofs == `OFS_POWER_SIGNALLING;
  wire hitCtrl = inRange && ofs == `OFS_TRANSCEIVER_CONTROL;
  wire hitStat = inRange && ofs == `OFS_IRQ_STATUS;
  wire hitMask = inRange && ofs == `OFS_IRQ_MASK;
  wire mapped = hitPid | hitEp | hitTag | hitOtg | hitPwr | hitCtrl | hitStat | hitMask;

  logic [31:0] rdMux;
  always_comb begin
    rdMux = 32'h0000_0000;
    if (hitPid) begin
      rdMux = {28'h0000000, pidReg};
    end else if (hitEp) begin
      rdMux = {27'h0000000, epValidReg, epReg};
    end else if (hitTag) begin
      rdMux = {16'h0000, tagMaskReg};
    end else if (hitOtg) begin
      rdMux = otgMaskReg;
    end else if (hitPwr) begin
      rdMux = {23'h000000, powerReg};
    end else if (hitCtrl) begin
      rdMux = ctrlReg;
    end else if (hitStat) begin
      rdMux = {28'h0000000, irqStatReg};
    end else if (hitMask) begin
      rdMux = {28'h0000000, irqMaskReg};
    end
  end

  // ****************************************
  // packet capture
  // ****************************************
  wire pktIn = rxPacket.valid;
  wire tokIn = pktIn && rxPacket.isToken;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      pidReg <= 4'h0;
      epReg <= 4'h0;
      epValidReg <= 1'b0;
    end else begin
      if (pktIn) begin
        pidReg <= rxPacket.pid;
      end
      if (tokIn) begin
        epReg <= rxPacket.endpoint;
        epValidReg <= 1'b1;
      end
    end
  end

  // tagged endpoint towards the receive port
  wire tagHit = tagMaskReg[rxPacket.endpoint];
  wire [4:0] tagEp = {1'b0, rxPacket.endpoint} | (tagHit ? `EP_TAG_OR : 5'h00);

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rxTag <= '0;
    end else begin
      rxTag.valid <= tokIn;
      if (tokIn) begin
        rxTag.endpoint <= tagEp;
      end
    end
  end

  // ****************************************
  // suspend controller
  // ****************************************
  usb_iface_mgr_pkg::power_state_t pwrState;
  logic [31:0] idleCnt;
  wire suspendEn = ctrlReg[`SUSPEND_EN_BIT];
  wire lineIdle = (lineFilt == usb_iface_mgr_pkg::LINE_J);
  wire lineSe0 = (lineFilt == usb_iface_mgr_pkg::LINE_SE0);
  wire lineK = (lineFilt == usb_iface_mgr_pkg::LINE_K);
  wire goSuspend = suspendEn && pwrState == usb_iface_mgr_pkg::PWR_ACTIVE &&
                   idleCnt >= 32'(SUSPEND_CYCLES);
  wire wakeSe0 = pwrState == usb_iface_mgr_pkg::PWR_SUSPENDED && lineSe0;
  wire wakeK = pwrState == usb_iface_mgr_pkg::PWR_SUSPENDED && lineK;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      pwrState <= usb_iface_mgr_pkg::PWR_ACTIVE;
      idleCnt <= 32'h0000_0000;
    end else begin
      case (pwrState)
        usb_iface_mgr_pkg::PWR_ACTIVE: begin
          if (!lineIdle || !suspendEn) begin
            idleCnt <= 32'h0000_0000;
          end else if (!goSuspend) begin
            idleCnt <= idleCnt + 32'h0000_0001;
          end
          if (goSuspend) begin
            pwrState <= usb_iface_mgr_pkg::PWR_SUSPENDED;
          end
        end
        usb_iface_mgr_pkg::PWR_SUSPENDED: begin
          if (wakeSe0 || wakeK) begin
            pwrState <= usb_iface_mgr_pkg::PWR_RESUMING;
          end else if (!suspendEn) begin
            pwrState <= usb_iface_mgr_pkg::PWR_ACTIVE;
          end
        end
        usb_iface_mgr_pkg::PWR_RESUMING: begin
          idleCnt <= 32'h0000_0000;
          pwrState <= usb_iface_mgr_pkg::PWR_ACTIVE;
        end
        default: begin
          pwrState <= usb_iface_mgr_pkg::PWR_ACTIVE;
        end
      endcase
    end
  end

  // ****************************************
  // register writes
  // ****************************************
  wire [31:0] ctrlWr = pwdata & `CTRL_WRITE_MASK;
  wire ctrlWrEn = wrEn && hitCtrl;
  // cause flags: hardware set wins over a software clear
  wire causeResetNext = wakeSe0 ||
       (ctrlWrEn ? pwdata[`CAUSE_RESET_BIT] : ctrlReg[`CAUSE_RESET_BIT]);
  wire causeResumeNext = wakeK ||
       (ctrlWrEn ? pwdata[`CAUSE_RESUME_BIT] : ctrlReg[`CAUSE_RESUME_BIT]);

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      tagMaskReg <= 16'h0000;
      otgMaskReg <= `RESET_WORD;
      powerReg <= 9'h000;
      irqMaskReg <= 4'h0;
      ctrlReg <= `RESET_WORD;
    end else begin
      if (wrEn && hitTag) begin
        tagMaskReg <= pwdata[15:0];
      end
      if (wrEn && hitOtg) begin
        otgMaskReg <= pwdata;
      end
      if (wrEn && hitPwr) begin
        powerReg <= pwdata[8:0];
      end
      if (wrEn && hitMask) begin
        irqMaskReg <= pwdata[3:0];
      end
      if (ctrlWrEn) begin
        ctrlReg <= ctrlWr;
      end
      ctrlReg[`CAUSE_RESET_BIT] <= causeResetNext;
      ctrlReg[`CAUSE_RESUME_BIT] <= causeResumeNext;
    end
  end

  // ****************************************
  // interrupt status
  // ****************************************
  logic [3:0] irqEvents;
  assign irqEvents = {goSuspend, wakeK, wakeSe0, pktIn};
  wire [3:0] irqClr = (wrEn && hitStat) ? pwdata[3:0] : 4'h0;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      irqStatReg <= 4'h0;
      irq <= 1'b0;
    end else begin
      irqStatReg <= (irqStatReg & ~irqClr) | irqEvents;
      irq <= |(((irqStatReg & ~irqClr) | irqEvents) & irqMaskReg);
    end
  end

  // ****************************************
  // outputs and bus answer
  // ****************************************
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      transceiver_config_pins <= 3'h0;
      pulldownOff <= 1'b0;
      suspendMode <= 1'b0;
      lineStateFilt <= 2'h1;
    end else begin
      pready <= psel && !pready;
      pslverr <= psel && !pready && !mapped;
      prdata <= (psel && !pready && !pwrite) ? rdMux : 32'h0000_0000;
      transceiver_config_pins <= ctrlReg[`CONF_MSB:`CONF_LSB];
      pulldownOff <= ctrlReg[`PULLDOWN_OFF_BIT];
      suspendMode <= (pwrState == usb_iface_mgr_pkg::PWR_SUSPENDED);
      lineStateFilt <= lineFilt;
    end
  end
endmodule : usb_phy_info_ctrl

/* verif/usb_phy_info_ctrl_assertions.sv */
module usb_phy_info_ctrl_checker #(
  parameter int SUSPEND_CYCLES = 20
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire usb_iface_mgr_pkg::rx_packet_t rxPacket,
  input wire usb_iface_mgr_pkg::rx_tag_t rxTag,
  input wire logic [1:0] lineStateFilt,
  input wire logic [2:0] transceiver_config_pins,
  input wire logic pulldownOff,
  input wire logic suspendMode
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  // ****
  // idle length seen on the filtered line
  // ****
  int idleCnt_reg;
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      idleCnt_reg <= 0;
    end else if (lineStateFilt == 2'h1) begin
      idleCnt_reg <= idleCnt_reg + 1;
    end else begin
      idleCnt_reg <= 0;
    end
  end
  sequence ctrl_write;
    psel && penable && pready && pwrite && paddr == 32'h40;
  endsequence
  chk_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  chk_ready_one_cycle: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  chk_err_with_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  chk_tag_after_token: assert property (
    rxPacket.valid && rxPacket.isToken |-> ##[1:2] rxTag.valid)
    else $error("no tag after token");
  chk_tag_holds: assert property ($changed(rxTag.endpoint) |-> rxTag.valid)
    else $error("tag endpoint moved without token");
  chk_pulldown_follows: assert property (
    ctrl_write |-> ##2 pulldownOff == $past(pwdata[18], 2))
    else $error("pulldown disable wrong");
  chk_conf_pins: assert property (
    ctrl_write |-> ##2 transceiver_config_pins == $past(pwdata[6:4], 2))
    else $error("config pins wrong");
  chk_suspend_entry: assert property (
    $rose(suspendMode) |-> idleCnt_reg >= SUSPEND_CYCLES - 2)
    else $error("suspend entered too early");
  // se0 or k on the line wakes
  chk_wake_prompt: assert property (
    suspendMode && !lineStateFilt[0] |-> ##[1:4] !suspendMode)
    else $error("no wake from suspend");
endmodule : usb_phy_info_ctrl_checker

bind usb_phy_info_ctrl usb_phy_info_ctrl_checker #(.SUSPEND_CYCLES(SUSPEND_CYCLES)) chk_u (
  .sys_clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr,
  .rxPacket, .rxTag, .lineStateFilt, .transceiver_config_pins, .pulldownOff, .suspendMode);

/* verif/usb_phy_partner.sv */
module usb_phy_partner (
  input wire logic sys_clk,
  output logic [1:0] lineStatePin,
  output usb_iface_mgr_pkg::rx_packet_t rxPacket
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    lineStatePin = 2'h1;
    rxPacket = '0;
  end
  // ****
  // one-cycle strobe, then fields scrambled
  // ****
  task automatic send(input logic tok, input logic [3:0] pid, input logic [3:0] ep);
    @(posedge sys_clk);
    rxPacket.valid <= 1'h1;
    rxPacket.isToken <= tok;
    rxPacket.pid <= pid;
    rxPacket.endpoint <= ep;
    @(posedge sys_clk);
    rxPacket.valid <= 1'h0;
    rxPacket.isToken <= ~tok;
    rxPacket.pid <= ~pid;
    rxPacket.endpoint <= ~ep;
  endtask : send
  // bus state: j idle, k resume, se0 reset
  task automatic line(input logic [1:0] ls);
    @(posedge sys_clk);
    lineStatePin <= ls;
  endtask : line
endmodule : usb_phy_partner

/* verif/usb_phy_info_ctrl_tb.sv */
module usb_phy_info_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  `define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin err_count++; \
    $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, a, e); end end
  logic sys_clk, rst_b, psel, penable, pwrite, pready, pslverr, er;
  logic pulldownOff, suspendMode, irq;
  logic [31:0] paddr, pwdata, prdata, rd;
  logic [1:0] lineStatePin, lineStateFilt;
  logic [2:0] transceiver_config_pins;
  usb_iface_mgr_pkg::rx_packet_t rxPacket;
  usb_iface_mgr_pkg::rx_tag_t rxTag;
  int err_count = 0;
  int num_checks = 0;
  usb_phy_info_ctrl #(.SUSPEND_CYCLES(20)) dut_u (.sys_clk, .rst_b, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .rxPacket, .lineStatePin, .rxTag,
    .lineStateFilt, .transceiver_config_pins, .pulldownOff, .suspendMode, .irq);
  usb_phy_partner phy_u (.sys_clk, .lineStatePin, .rxPacket);
  initial begin
    sys_clk = 1'h0;
    forever #25 sys_clk = ~sys_clk;
  end
  // ****
  // bus helpers
  // ****
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    int n;
    @(posedge sys_clk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= psel;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    // no answer within the limit counts as a mismatch
    if (pready !== 1'h1) begin
      err_count++;
    end
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'h0;
  endtask : apb
  task automatic rd_chk(input logic [31:0] a, input logic [31:0] e);
    apb(1'h0, a, 32'h0);
    `CHK(rd, e)
  endtask : rd_chk
  task automatic wait_sus(input logic v);
    for (int n = 0; n < 60 && suspendMode !== v; n++) @(posedge sys_clk);
    `CHK(suspendMode, v)
  endtask : wait_sus
  // ****
  // scenarios
  // ****
  task automatic t_regs;
    `CHK(lineStateFilt, 2'h1)
    for (int i = 0; i < 6; i++) rd_chk(32'h2C + 4 * i, 32'h0);
    apb(1'h1, 32'h30, 32'h1F);
    rd_chk(32'h30, 32'h0);
    apb(1'h1, 32'h3C, 32'hFFFF_FFFF);
    rd_chk(32'h3C, 32'h1FF);
    apb(1'h1, 32'h34, 32'hFFFF_FFFF);
    rd_chk(32'h34, 32'hFFFF);
    apb(1'h0, 32'h50, 32'h0);
    `CHK({er, rd}, 33'h1_0000_0000)
  endtask : t_regs
  task automatic t_packet;
    apb(1'h1, 32'h34, 32'h20);
    phy_u.send(1'h1, 4'h9, 4'h5);
    repeat (3) @(posedge sys_clk);
    `CHK(rxTag.endpoint, 5'h15)
    rd_chk(32'h2C, 32'h9);
    rd_chk(32'h30, 32'h15);
    phy_u.send(1'h0, 4'h3, 4'h7);
    rd_chk(32'h2C, 32'h3);
    rd_chk(32'h30, 32'h15);
    phy_u.send(1'h1, 4'hD, 4'h2);
    repeat (3) @(posedge sys_clk);
    `CHK({rxTag.endpoint, irq}, 6'h04)
  endtask : t_packet
  task automatic t_ctrl;
    apb(1'h1, 32'h40, 32'h0004_0050);
    repeat (2) @(posedge sys_clk);
    `CHK({pulldownOff, transceiver_config_pins}, 4'hD)
    rd_chk(32'h40, 32'h0004_0050);
    apb(1'h1, 32'h40, 32'h300);
    phy_u.line(2'h2);
    repeat (6) @(posedge sys_clk);
    `CHK(lineStateFilt, 2'h1)
    repeat (10) @(posedge sys_clk);
    `CHK({pulldownOff, transceiver_config_pins, lineStateFilt}, 6'h2)
    phy_u.line(2'h1);
    repeat (16) @(posedge sys_clk);
  endtask : t_ctrl
  task automatic t_suspend;
    apb(1'h1, 32'h40, 32'h0);
    apb(1'h1, 32'h44, 32'hF);
    apb(1'h1, 32'h48, 32'h8);
    apb(1'h1, 32'h40, 32'h80);
    wait_sus(1'h1);
    repeat (2) @(posedge sys_clk);
    `CHK(irq, 1'h1)
    apb(1'h1, 32'h44, 32'h8);
    phy_u.line(2'h2);
    wait_sus(1'h0);
    repeat (2) @(posedge sys_clk);
    `CHK(irq, 1'h0)
    rd_chk(32'h40, 32'h1080);
    apb(1'h1, 32'h40, 32'h80);
    rd_chk(32'h40, 32'h80);
    phy_u.line(2'h1);
    wait_sus(1'h1);
    phy_u.line(2'h0);
    wait_sus(1'h0);
    rd_chk(32'h40, 32'h2080);
    apb(1'h1, 32'h40, 32'h0);
    rd_chk(32'h40, 32'h0);
    phy_u.line(2'h1);
    repeat (40) @(posedge sys_clk);
    `CHK(suspendMode, 1'h0)
  endtask : t_suspend
  task automatic finish_test;
    if (err_count == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : finish_test
  initial begin
    rst_b = 1'h0;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 32'h0000_0000;
    pwdata = 32'h0000_0000;
    repeat (12) @(posedge sys_clk);
    rst_b <= 1'h1;
    t_regs;
    t_packet;
    t_ctrl;
    t_suspend;
    finish_test;
  end
  initial begin
    #(50 * 20000);
    err_count++;
    finish_test;
  end
endmodule : usb_phy_info_ctrl_tb
